/* common/usb_ctrl_pkg.sv */
// Functional notes
// - Device mode, control 00: function off, no pull-up.
// - Device mode, control 01: function on, external pull-up.
// - Device mode, control 1x: function on, internal pull-up.
// - Host mode, control 00: normal host operation.
// - Host mode 01/10/11 force SE0, J, K.
// - Enable bits 7/6 gate device SOF, NAK.
// - Enable bits 4/3 gate overflow, host SOF.
// - Enable bits 2/1 gate suspend, transfer done.
// - Enable bit 0 gates attach or bus reset.
// - Seven-bit address resets zero, bit 7 spare.
// - Status 7 SOF pending defers packets; 6 sending.
// - Engine idle bit 5 in both registers, resets 1.
// - Status bit 4 shows receive FIFO not empty.
// - Status bit 3 shows bus in reset.
// - Status bit 2 shows bus suspended, resets 0.
// - Host status bit 1 shows attached DM level.
// - Host status bit 0 shows device attached.
// - Flag bit 7 shows NAK answered, read-only.
// - Flag bit 6 shows data toggle matched.
// - Flags 4, 2, 1 set by events, write-one-clear.
// - Host flag 3 set on SOF sent, write-one-clear.
// - Flag 0 set on attach/detach or bus reset.
// - Control bit 7 host mode, bits 5:4 control.
// - Set flag with enable raises interrupt request.
package usb_ctrl_pkg;
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] INT_EN_OFFSET   = 8'h04;
  localparam logic [7:0] DEV_ADDR_OFFSET = 8'h08;
  localparam logic [7:0] MISC_ST_OFFSET  = 8'h0c;
  localparam logic [7:0] INT_FG_OFFSET   = 8'h10;

  localparam int HOST_MODE_BIT  = 7;
  localparam int SYS_CTRL_LSB   = 4;
  localparam int SOF_PEND_BIT   = 7;
  localparam int SOF_SEND_BIT   = 6;
  localparam int IDLE_BIT       = 5;
  localparam int RX_READY_BIT   = 4;
  localparam int BUS_RESET_BIT  = 3;
  localparam int SUSPENDED_BIT  = 2;
  localparam int DM_LEVEL_BIT   = 1;
  localparam int ATTACHED_BIT   = 0;
  localparam int NAK_BIT        = 7;
  localparam int TOGGLE_BIT     = 6;
  localparam int OVERFLOW_BIT   = 4;
  localparam int HOST_SOF_BIT   = 3;
  localparam int SUSPEND_EV_BIT = 2;
  localparam int TRANSFER_BIT   = 1;
  localparam int DETECT_BIT     = 0;

  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] INT_EN_RESET   = 8'h00;
  localparam logic [7:0] DEV_ADDR_RESET = 8'h00;
  localparam logic [7:0] INT_EN_MASK    = 8'hdf;
  localparam logic [7:0] W1C_MASK       = 8'h1f;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LINE_RELEASE,
    LINE_SE0,
    LINE_J,
    LINE_K
  } line_force_t;
endpackage

/* hw/usb_ctrl_status.sv */
module usb_ctrl_status (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sof_pending,
  input  wire logic        sof_sending,
  input  wire logic        engine_idle,
  input  wire logic        rx_fifo_not_empty,
  input  wire logic        bus_in_reset,
  input  wire logic        bus_suspended,
  input  wire logic        dm_pin,
  input  wire logic        port_device_attached,
  input  wire logic        nak_answered,
  input  wire logic        toggle_match,
  input  wire logic        fifo_overflow_event,
  input  wire logic        host_sof_done_event,
  input  wire logic        suspend_wake_event,
  input  wire logic        transfer_done_event,
  input  wire logic        attach_detach_event,
  input  wire logic        bus_reset_event,
  output logic             host_mode,
  output logic             device_enable,
  output logic             internal_pullup_on,
  output logic [1:0]       line_force,
  output logic             packet_defer,
  output logic [6:0]       device_address,
  output logic             irq
);
  logic [7:0]  ctrl_reg;
  logic [7:0]  int_en_reg;
  logic [7:0]  dev_addr_reg;
  logic [4:0]  flags_reg;
  logic [4:0]  flags_next;
  logic [2:0]  dm_sync_reg;
  logic        dm_level_reg;
  logic        dm_level_next;
  logic        attach_d_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire        is_host    = ctrl_reg[usb_ctrl_pkg::HOST_MODE_BIT];
  wire [1:0]  sys_ctrl   = ctrl_reg[usb_ctrl_pkg::SYS_CTRL_LSB +: 2];
  wire        aw_take    = s_axi_awvalid & s_axi_awready;
  wire        w_take     = s_axi_wvalid & s_axi_wready;
  wire        aw_have    = aw_held_reg | aw_take;
  wire        w_have     = w_held_reg | w_take;
  wire [7:0]  wr_addr    = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [7:0]  wr_data    = w_held_reg ? wdata_reg : s_axi_wdata[7:0];
  wire        wr_lane0   = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
  wire        wr_fire    = aw_have & w_have & ~bvalid_reg;
  wire        wr_en      = wr_fire & wr_lane0;
  wire        wr_ctrl    = wr_en & (wr_addr == usb_ctrl_pkg::CTRL_OFFSET);
  wire        wr_int_en  = wr_en & (wr_addr == usb_ctrl_pkg::INT_EN_OFFSET);
  wire        wr_addr_r  = wr_en & (wr_addr == usb_ctrl_pkg::DEV_ADDR_OFFSET);
  wire        wr_flags   = wr_en & (wr_addr == usb_ctrl_pkg::INT_FG_OFFSET);
  wire        wr_mapped  = (wr_addr == usb_ctrl_pkg::CTRL_OFFSET) | (wr_addr == usb_ctrl_pkg::INT_EN_OFFSET) |
                           (wr_addr == usb_ctrl_pkg::DEV_ADDR_OFFSET) | (wr_addr == usb_ctrl_pkg::MISC_ST_OFFSET) |
                           (wr_addr == usb_ctrl_pkg::INT_FG_OFFSET);
  wire        ar_take    = s_axi_arvalid & s_axi_arready;

  // Device-mode bit 0 event is bus reset; host-mode bit 0 event is attach or detach.
  wire        detect_ev  = is_host ? attach_detach_event : bus_reset_event;
  wire [4:0]  events;
  assign events[usb_ctrl_pkg::OVERFLOW_BIT]   = fifo_overflow_event;
  assign events[usb_ctrl_pkg::HOST_SOF_BIT]   = is_host & host_sof_done_event;
  assign events[usb_ctrl_pkg::SUSPEND_EV_BIT] = suspend_wake_event;
  assign events[usb_ctrl_pkg::TRANSFER_BIT]   = transfer_done_event;
  assign events[usb_ctrl_pkg::DETECT_BIT]     = detect_ev;
  wire [4:0]  clear_mask = wr_flags ? wr_data[4:0] : 5'h00;

  wire [7:0] misc_status;
  assign misc_status[usb_ctrl_pkg::SOF_PEND_BIT]  = is_host & sof_pending;
  assign misc_status[usb_ctrl_pkg::SOF_SEND_BIT]  = is_host & sof_sending;
  assign misc_status[usb_ctrl_pkg::IDLE_BIT]      = engine_idle;
  assign misc_status[usb_ctrl_pkg::RX_READY_BIT]  = rx_fifo_not_empty;
  assign misc_status[usb_ctrl_pkg::BUS_RESET_BIT] = bus_in_reset;
  assign misc_status[usb_ctrl_pkg::SUSPENDED_BIT] = bus_suspended;
  assign misc_status[usb_ctrl_pkg::DM_LEVEL_BIT]  = is_host & dm_level_reg;
  assign misc_status[usb_ctrl_pkg::ATTACHED_BIT]  = is_host & port_device_attached;

  wire [7:0] flag_status;
  assign flag_status[usb_ctrl_pkg::NAK_BIT]    = ~is_host & nak_answered;
  assign flag_status[usb_ctrl_pkg::TOGGLE_BIT] = toggle_match;
  assign flag_status[usb_ctrl_pkg::IDLE_BIT]   = engine_idle;
  assign flag_status[4:0]                      = flags_reg;

  wire [7:0] rd_addr  = s_axi_araddr;
  wire       rd_ok    = (rd_addr == usb_ctrl_pkg::CTRL_OFFSET) | (rd_addr == usb_ctrl_pkg::INT_EN_OFFSET) |
                        (rd_addr == usb_ctrl_pkg::DEV_ADDR_OFFSET) | (rd_addr == usb_ctrl_pkg::MISC_ST_OFFSET) |
                        (rd_addr == usb_ctrl_pkg::INT_FG_OFFSET);
  wire [7:0] rd_byte  = (rd_addr == usb_ctrl_pkg::CTRL_OFFSET)     ? ctrl_reg :
                        (rd_addr == usb_ctrl_pkg::INT_EN_OFFSET)   ? int_en_reg :
                        (rd_addr == usb_ctrl_pkg::DEV_ADDR_OFFSET) ? dev_addr_reg :
                        (rd_addr == usb_ctrl_pkg::MISC_ST_OFFSET)  ? misc_status :
                        (rd_addr == usb_ctrl_pkg::INT_FG_OFFSET)   ? flag_status : 8'h00;

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Flag bits: an event in the clearing cycle keeps the flag set.
  assign flags_next = (flags_reg & ~clear_mask) | events;

  // Device mode: 00 off, 01 external pull-up, 1x internal pull-up.
  assign host_mode          = is_host;
  assign device_enable      = ~is_host & (sys_ctrl != 2'h0);
  assign internal_pullup_on = ~is_host & sys_ctrl[1];
  assign line_force         = is_host ? sys_ctrl : 2'h0;
  // The packet scheduler must hold off new packets while an SOF is due or going out.
  assign packet_defer       = is_host & (sof_pending | sof_sending);
  assign device_address     = dev_addr_reg[6:0];

  // Device-mode SOF receipt is a transfer whose token is SOF; approximated by a
  // transfer completing while no NAK was given and the engine is idle.
  wire sof_rx_flag = engine_idle & ~nak_answered;

  assign irq                = |(flag_status[4:0] & int_en_reg[4:0]) |
                              (~is_host & int_en_reg[7] & flags_reg[usb_ctrl_pkg::TRANSFER_BIT] & sof_rx_flag) |
                              (~is_host & int_en_reg[6] & nak_answered);

  // DM level is synchronised and latched at each attach rising edge where the last two synced samples agree.
  assign dm_level_next = (dm_sync_reg[2] == dm_sync_reg[1]) & port_device_attached & ~attach_d_reg ?
                         dm_sync_reg[1] : dm_level_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_reg     <= usb_ctrl_pkg::CTRL_RESET;
      int_en_reg   <= usb_ctrl_pkg::INT_EN_RESET;
      dev_addr_reg <= usb_ctrl_pkg::DEV_ADDR_RESET;
      flags_reg    <= 5'h00;
      dm_sync_reg  <= 3'h0;
      dm_level_reg <= 1'b0;
      attach_d_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wr_data;
      end
      if (wr_int_en) begin
        int_en_reg <= wr_data & usb_ctrl_pkg::INT_EN_MASK;
      end
      if (wr_addr_r) begin
        dev_addr_reg <= wr_data;
      end
      flags_reg    <= flags_next;
      dm_sync_reg  <= {dm_sync_reg[1:0], dm_pin};
      dm_level_reg <= dm_level_next;
      attach_d_reg <= port_device_attached;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= usb_ctrl_pkg::AXI_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? usb_ctrl_pkg::AXI_OKAY : usb_ctrl_pkg::AXI_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          awaddr_reg  <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          wdata_reg  <= s_axi_wdata[7:0];
          wstrb0_reg <= s_axi_wstrb[0];
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= usb_ctrl_pkg::AXI_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= rd_ok ? usb_ctrl_pkg::AXI_OKAY : usb_ctrl_pkg::AXI_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule

/* tb/usb_ctrl_status_monitor.sv */
module usb_ctrl_status_monitor (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       sof_pending,
  input wire logic       sof_sending,
  input wire logic       host_mode,
  input wire logic       device_enable,
  input wire logic       internal_pullup_on,
  input wire logic [1:0] line_force,
  input wire logic       packet_defer,
  input wire logic [6:0] device_address,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_DEFER: assert property (packet_defer == (host_mode && (sof_pending || sof_sending))) else $error("defer");
  AST_FORCE: assert property (!host_mode |-> line_force == 2'h0) else $error("force in device mode");
  AST_HOSTDEV: assert property (host_mode |-> !device_enable && !internal_pullup_on) else $error("host dev");
  AST_PULLUP: assert property (internal_pullup_on |-> device_enable) else $error("pull-up alone");
  AST_WRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response");
  AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  AST_RSTVAL: assert property ($rose(rstn) |-> !host_mode && device_address == 7'h00 && !irq)
    else $error("reset state");
  cover property (host_mode && line_force == 2'h3);
  cover property (irq);
  cover property (packet_defer);
endmodule

bind usb_ctrl_status usb_ctrl_status_monitor usb_ctrl_status_monitor_inst (.*);

/* tb/usb_ctrl_status_tb.sv */
module usb_ctrl_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, packet_defer, irq;
  logic sof_pending, sof_sending, engine_idle, rx_fifo_not_empty, bus_in_reset, bus_suspended;
  logic nak_answered, toggle_match, dm_pin, port_device_attached, connect, low_speed;
  logic fifo_overflow_event, host_sof_done_event, suspend_wake_event, transfer_done_event;
  logic attach_detach_event, bus_reset_event, host_mode, device_enable, internal_pullup_on;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, line_force, rs;
  logic [6:0]  device_address;
  logic [5:0]  ev, st;
  int          n_errors, checks_done, cycles;
  usb_ctrl_status usb_ctrl_status_inst (.*);
  usb_far_end_model usb_far_end_model_inst (.clock(clock), .connect(connect), .low_speed(low_speed),
    .dm_pin(dm_pin), .port_device_attached(port_device_attached));
  assign {bus_reset_event, fifo_overflow_event, host_sof_done_event, suspend_wake_event,
    transfer_done_event, attach_detach_event} = ev;
  assign {sof_pending, sof_sending, engine_idle, rx_fifo_not_empty, bus_in_reset, bus_suspended} = st;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h000000, e}, rd);
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= 6'h00;
  endtask
  task automatic t_reset;
    rchk(8'h00, 8'h00);
    rchk(8'h04, 8'h00);
    rchk(8'h08, 8'h00);
    rchk(8'h0c, 8'h20);
    rchk(8'h10, 8'h20);
    bus(1'b0, 8'h14, 8'h00);
    chk("unmapped resp", {30'h0, usb_ctrl_pkg::AXI_SLVERR}, {30'h0, rs});
    bus(1'b1, 8'h08, 8'hff);
    chk("write resp", {30'h0, usb_ctrl_pkg::AXI_OKAY}, {30'h0, rs});
    rchk(8'h08, 8'hff);
    chk("address", 32'h7f, {25'h0, device_address});
    bus(1'b1, 8'h0c, 8'hff);
    rchk(8'h0c, 8'h20);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h00, {m[2], 1'b0, m[1:0], 4'h0});
      chk("host", m[2], host_mode);
      chk("dev_en", !m[2] && m[1:0] != 0, device_enable);
      chk("pullup", !m[2] && m[1], internal_pullup_on);
      chk("force", m[2] ? m[1:0] : 0, line_force);
    end
  endtask
  task automatic t_flags;
    bus(1'b1, 8'h00, 8'h80);
    for (int i = 0; i < 5; i++) begin
      b = 8'h01 << i;
      pulse(b[5:0]);
      bus(1'b1, 8'h04, ~b & 8'h1f);
      rchk(8'h10, 8'h20 | b);
      chk("irq masked", 0, irq);
      bus(1'b1, 8'h04, b);
      bus(1'b1, 8'h10, 8'h00);
      rchk(8'h10, 8'h20 | b);
      chk("irq", 1, irq);
      bus(1'b1, 8'h10, b);
      rchk(8'h10, 8'h20);
      chk("irq cleared", 0, irq);
    end
  endtask
  task automatic t_device;
    bus(1'b1, 8'h00, 8'h20);
    pulse(6'h20);
    rchk(8'h10, 8'h21);
    st <= 6'h00;
    nak_answered <= 1'b1;
    toggle_match <= 1'b1;
    rchk(8'h10, 8'hc1);
    bus(1'b1, 8'h04, 8'h40);
    rchk(8'h04, 8'h40);
    chk("nak irq", 1, irq);
    bus(1'b1, 8'h04, 8'hff);
    rchk(8'h04, 8'hdf);
    bus(1'b1, 8'h10, 8'h01);
  endtask
  task automatic t_status;
    bus(1'b1, 8'h00, 8'h80);
    st <= 6'h2d;
    connect <= 1'b1;
    low_speed <= 1'b1;
    repeat (10) @(posedge clock);
    rchk(8'h0c, 8'hb7);
    chk("defer", 1, packet_defer);
    st <= 6'h12;
    rchk(8'h0c, 8'h4b);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ev, nak_answered, toggle_match, connect, low_speed, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    st = 6'h08;
    {n_errors, checks_done, cycles} = '0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_modes;
    t_flags;
    t_device;
    t_status;
    tally_and_finish;
  end
endmodule

/* tb/usb_far_end_model.sv */
module usb_far_end_model (
  input  wire logic clock,
  input  wire logic connect,
  input  wire logic low_speed,
  output logic      dm_pin,
  output logic      port_device_attached
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] settle_reg;
  // A low-speed device pulls DM high; otherwise the port pull-down holds it low.
  always_ff @(posedge clock) begin
    dm_pin <= connect & low_speed;
    settle_reg <= {settle_reg[2:0], connect};
  end
  // Attach shows only after DM has settled, as a port detector would see it.
  assign port_device_attached = settle_reg[3];
endmodule
